/* hdl/ubr_baud_gen.sv */
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module ubr_baud_gen (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Register port
    input wire logic [ubr_pkg::AW-1:0] ADDR,
    input wire logic [ubr_pkg::DW-1:0] WDATA,
    input wire logic [ubr_pkg::DW-1:0] BIT_MASK,
    input wire logic WR,
    input wire logic RD,
    output logic [ubr_pkg::DW-1:0] RDATA,
    // Receiver side
    input wire logic [ubr_pkg::CHANNELS-1:0] RX_START,
    output logic [ubr_pkg::CHANNELS-1:0] RX_SAMPLE,
    // Serial clock outputs
    output logic [ubr_pkg::CHANNELS-1:0] BAUD_OUT,
    output logic [ubr_pkg::CHANNELS-1:0] SER_CLK
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic [ubr_pkg::MODE_SEL_W-1:0] sel;
        logic [ubr_pkg::DW-1:0] cmp;
        logic src;
        logic [ubr_pkg::PRE_W-1:0] pre;
        logic [ubr_pkg::DW-1:0] cnt;
        logic baud;
        logic sclk;
        logic [ubr_pkg::SMP_W-1:0] smp;
        logic sample;
    } ubr_ch_t;

    typedef struct packed {
        ubr_ch_t [ubr_pkg::CHANNELS-1:0] ch;
        logic [ubr_pkg::DW-1:0] rdata;
    } ubr_state_t;

    ubr_state_t q;
    ubr_state_t d;
    logic [ubr_pkg::CHANNELS-1:0] match;
    logic [ubr_pkg::CHANNELS-1:0] tick;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [ubr_pkg::AW-1:0] reg_addr(input int ch, input ubr_pkg::ubr_kind_t kind);
        logic [ubr_pkg::AW-1:0] a;
        case (kind)
            ubr_pkg::KIND_MODE: a = (ch == 0) ? ubr_pkg::ADDR_MODE_CH1 : ubr_pkg::ADDR_MODE_CH2;
            ubr_pkg::KIND_CMP: a = (ch == 0) ? ubr_pkg::ADDR_CMP_CH1 : ubr_pkg::ADDR_CMP_CH2;
            default: a = (ch == 0) ? ubr_pkg::ADDR_SRC_CH1 : ubr_pkg::ADDR_SRC_CH2;
        endcase
        return a;
    endfunction

    // Count clock enable from the channel prescaler, held at zero while disabled
    function automatic logic pre_tick(input logic [ubr_pkg::PRE_W-1:0] pre,
                                      input logic [ubr_pkg::MODE_SEL_W-1:0] sel);
        logic t;
        case (ubr_pkg::ubr_sel_t'(sel))
            ubr_pkg::SEL_DIV2: t = pre[0];
            ubr_pkg::SEL_DIV4: t = &pre[1:0];
            ubr_pkg::SEL_DIV8: t = &pre[2:0];
            default: t = &pre[3:0];
        endcase
        return t;
    endfunction

    // Zero wraps to the last count of 256
    function automatic logic [ubr_pkg::DW-1:0] last_count(input logic [ubr_pkg::DW-1:0] cmp);
        return cmp - ubr_pkg::CNT_STEP;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdata = '0;
        match = '0;
        tick = '0;
        for (int i = 0; i < ubr_pkg::CHANNELS; i++) begin
            // Counter and baud output
            if (!q.ch[i].en) begin
                d.ch[i].pre = '0;
                d.ch[i].cnt = '0;
                d.ch[i].baud = 1'b0;
            end else begin
                d.ch[i].pre = q.ch[i].pre + ubr_pkg::PRE_STEP;
                tick[i] = pre_tick(q.ch[i].pre, q.ch[i].sel);
                if (tick[i]) begin
                    if (q.ch[i].cnt == last_count(q.ch[i].cmp)) begin
                        match[i] = 1'b1;
                        d.ch[i].cnt = '0;
                        d.ch[i].baud = ~q.ch[i].baud;
                    end else begin
                        d.ch[i].cnt = q.ch[i].cnt + ubr_pkg::CNT_STEP;
                    end
                end
            end
            // One serial clock enable serves transmit and receive alike
            if (q.ch[i].src) begin
                d.ch[i].sclk = match[i] & ~q.ch[i].baud;
            end else begin
                d.ch[i].sclk = 1'b1;
            end
            // Receive sample timing
            d.ch[i].sample = 1'b0;
            if (RX_START[i]) begin
                d.ch[i].smp = '0;
            end else if (q.ch[i].sclk) begin
                d.ch[i].smp = q.ch[i].smp + ubr_pkg::SMP_STEP;
                d.ch[i].sample = (q.ch[i].smp == ubr_pkg::SMP_LAST);
            end
            // Register writes
            if (WR && ADDR == reg_addr(i, ubr_pkg::KIND_MODE)) begin
                if (BIT_MASK[ubr_pkg::MODE_EN_BIT]) begin
                    d.ch[i].en = WDATA[ubr_pkg::MODE_EN_BIT];
                end
                for (int b = 0; b < ubr_pkg::MODE_SEL_W; b++) begin
                    if (BIT_MASK[ubr_pkg::MODE_SEL_LSB + b]) begin
                        d.ch[i].sel[b] = WDATA[ubr_pkg::MODE_SEL_LSB + b];
                    end
                end
            end
            if (WR && ADDR == reg_addr(i, ubr_pkg::KIND_CMP)) begin
                d.ch[i].cmp = WDATA;
                d.ch[i].cnt = '0;
            end
            if (WR && ADDR == reg_addr(i, ubr_pkg::KIND_SRC)) begin
                d.ch[i].src = WDATA[ubr_pkg::SRC_BIT];
            end
            // Register reads; unused mode bits stay zero
            if (RD && ADDR == reg_addr(i, ubr_pkg::KIND_MODE)) begin
                d.rdata[ubr_pkg::MODE_EN_BIT] = q.ch[i].en;
                d.rdata[ubr_pkg::MODE_SEL_LSB +: ubr_pkg::MODE_SEL_W] = q.ch[i].sel;
            end
            if (RD && ADDR == reg_addr(i, ubr_pkg::KIND_CMP)) begin
                d.rdata = q.ch[i].cmp;
            end
            if (RD && ADDR == reg_addr(i, ubr_pkg::KIND_SRC)) begin
                d.rdata[ubr_pkg::SRC_BIT] = q.ch[i].src;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // All reset values (mode, compare, source) are zero
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        RDATA = q.rdata;
        for (int i = 0; i < ubr_pkg::CHANNELS; i++) begin
            BAUD_OUT[i] = q.ch[i].baud;
            SER_CLK[i] = q.ch[i].sclk;
            RX_SAMPLE[i] = q.ch[i].sample;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    for (genvar g = 0; g < ubr_pkg::CHANNELS; g++) begin : g_chk
        property p_hold_low;
            !q.ch[g].en ##1 !q.ch[g].en |-> !BAUD_OUT[g];
        endproperty
        a_hold_low: assert property (p_hold_low) else $error("baud output not low while disabled");

        property p_start;
            $rose(q.ch[g].en) && q.ch[g].cmp == 8'h01 && q.ch[g].sel == 2'h0 && !WR
                |-> ##[1:4] $rose(BAUD_OUT[g]);
        endproperty
        a_start: assert property (p_start) else $error("baud output did not start");

        property p_cmp_clear;
            WR && ADDR == reg_addr(g, ubr_pkg::KIND_CMP) |=> q.ch[g].cnt == 8'h00;
        endproperty
        a_cmp_clear: assert property (p_cmp_clear) else $error("compare write did not clear counter");

        property p_match_toggle;
            match[g] && !(WR && ADDR == reg_addr(g, ubr_pkg::KIND_MODE)) |=> BAUD_OUT[g] != $past(BAUD_OUT[g]);
        endproperty
        a_match_toggle: assert property (p_match_toggle) else $error("match did not invert baud");

        property p_wrap_256;
            match[g] && q.ch[g].cmp == 8'h00 |-> q.ch[g].cnt == 8'hff;
        endproperty
        a_wrap_256: assert property (p_wrap_256) else $error("zero compare did not count 256");

        property p_period;
            q.ch[g].en && q.ch[g].sel == 2'h0 && q.ch[g].cmp == 8'h02 && !WR && $changed(BAUD_OUT[g])
                ##1 (q.ch[g].en && !WR)[*3]
                |-> ##1 $changed(BAUD_OUT[g]) && $past(BAUD_OUT[g], 3) == $past(BAUD_OUT[g]);
        endproperty
        a_period: assert property (p_period) else $error("baud half period wrong");

        property p_div4;
            q.ch[g].en && q.ch[g].sel == 2'h1 && q.ch[g].cmp == 8'h01 && !WR && $changed(BAUD_OUT[g])
                ##1 (q.ch[g].en && !WR)[*3] |-> ##1 $changed(BAUD_OUT[g]);
        endproperty
        a_div4: assert property (p_div4) else $error("divide by four rate wrong");

        property p_fxx_src;
            !q.ch[g].src |=> SER_CLK[g];
        endproperty
        a_fxx_src: assert property (p_fxx_src) else $error("system clock source not passed");

        property p_restart;
            RX_START[g] |=> q.ch[g].smp == 4'h0 && !RX_SAMPLE[g];
        endproperty
        a_restart: assert property (p_restart) else $error("start bit did not restart timing");

        property p_sample;
            RX_SAMPLE[g] |-> $past(q.ch[g].smp) == 4'hf && $past(SER_CLK[g]);
        endproperty
        a_sample: assert property (p_sample) else $error("sample not on sixteenth clock");

        c_baud_rise: cover property ($rose(BAUD_OUT[g]));
        c_sample: cover property (RX_SAMPLE[g]);
        c_wrap: cover property (match[g] && q.ch[g].cmp == 8'h00);
        c_cmp_live: cover property (q.ch[g].en && WR && ADDR == reg_addr(g, ubr_pkg::KIND_CMP));
    end

    property p_mode_zero;
        RD && (ADDR == ubr_pkg::ADDR_MODE_CH1 || ADDR == ubr_pkg::ADDR_MODE_CH2) |=> RDATA[6:2] == 5'h00;
    endproperty
    a_mode_zero: assert property (p_mode_zero) else $error("unused mode bits read nonzero");

endmodule

/* pkg/ubr_pkg.sv */
package ubr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int CHANNELS = 2;
    localparam int AW = 32;
    localparam int DW = 8;
    localparam logic [AW-1:0] ADDR_MODE_CH1 = 32'hfffffa2e;
    localparam logic [AW-1:0] ADDR_MODE_CH2 = 32'hfffffa4e;
    localparam logic [AW-1:0] ADDR_CMP_CH1 = 32'hfffffa30;
    localparam logic [AW-1:0] ADDR_CMP_CH2 = 32'hfffffa50;
    localparam logic [AW-1:0] ADDR_SRC_CH1 = 32'hfffffa31;
    localparam logic [AW-1:0] ADDR_SRC_CH2 = 32'hfffffa51;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_SEL_W = 2;
    localparam int SRC_BIT = 0;
    localparam logic [DW-1:0] MODE_RST = 8'h00;
    localparam logic [DW-1:0] CMP_RST = 8'h00;
    localparam logic SRC_RST = 1'b0;
    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam int PRE_W = 4;
    localparam int SMP_W = 4;
    localparam logic [SMP_W-1:0] SMP_LAST = 4'hf;
    localparam logic [DW-1:0] CNT_STEP = 8'h01;
    localparam logic [PRE_W-1:0] PRE_STEP = 4'h1;
    localparam logic [SMP_W-1:0] SMP_STEP = 4'h1;
    typedef enum logic [1:0] {SEL_DIV2, SEL_DIV4, SEL_DIV8, SEL_DIV16} ubr_sel_t;
    typedef enum logic [1:0] {KIND_MODE, KIND_CMP, KIND_SRC} ubr_kind_t;
endpackage

/* verification/ubr_rx_model.sv */
`timescale 1ns/10ps
module ubr_rx_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic kick,
    // Generator side, and results to the bench
    input wire logic ser_clk,
    input wire logic rx_sample,
    output logic rx_start,
    output logic done,
    output logic [7:0] count
);
    // --------------------------------------------------
    // Start pulse and serial clock count
    // --------------------------------------------------
    // Start is a plain pulse, low between frames
    assign rx_start = kick;
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
            count <= 8'h00;
        end else if (rx_start) begin
            done <= 1'b0;
            count <= 8'h00;
        end else if (rx_sample) begin
            done <= 1'b1;
        end else if (ser_clk && !done) begin
            count <= count + 8'h01;
        end
    end
endmodule

/* verification/uart_baud_rate_generator_bench.sv */
`timescale 1ns/10ps
module uart_baud_rate_generator_bench;
    typedef struct {int ch; logic [1:0] sel; logic [7:0] cmp; int half;} ubr_row_t;
    localparam logic [31:0] A_MODE [2] = '{ubr_pkg::ADDR_MODE_CH1, ubr_pkg::ADDR_MODE_CH2};
    localparam logic [31:0] A_CMP [2] = '{ubr_pkg::ADDR_CMP_CH1, ubr_pkg::ADDR_CMP_CH2};
    localparam logic [31:0] A_SRC [2] = '{ubr_pkg::ADDR_SRC_CH1, ubr_pkg::ADDR_SRC_CH2};
    // Half periods in MCLK cycles; row 4 sits at a legal async rate
    ubr_row_t rows [8] = '{'{0, 2'h0, 8'h01, 2}, '{0, 2'h1, 8'h03, 12}, '{0, 2'h2, 8'h02, 16},
                           '{0, 2'h3, 8'h01, 16}, '{1, 2'h0, 8'h00, 512}, '{1, 2'h3, 8'h05, 80},
                           '{0, 2'h0, 8'h02, 4}, '{1, 2'h1, 8'h01, 4}};
    logic MCLK, SYS_RST, WR, RD;
    logic [31:0] ADDR;
    logic [7:0] WDATA, BIT_MASK, RDATA, rv;
    logic [1:0] RX_START, RX_SAMPLE, BAUD_OUT, SER_CLK, kick, done;
    logic [7:0] cnt [2];
    int err_count, samples_checked, hi, lo, ns, t;

    ubr_baud_gen i_ubr_baud_gen (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
        .BIT_MASK(BIT_MASK), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_START(RX_START),
        .RX_SAMPLE(RX_SAMPLE), .BAUD_OUT(BAUD_OUT), .SER_CLK(SER_CLK));
    ubr_rx_model i_ubr_rx_model_0 (.clk(MCLK), .rst(SYS_RST), .kick(kick[0]), .ser_clk(SER_CLK[0]),
        .rx_sample(RX_SAMPLE[0]), .rx_start(RX_START[0]), .done(done[0]), .count(cnt[0]));
    ubr_rx_model i_ubr_rx_model_1 (.clk(MCLK), .rst(SYS_RST), .kick(kick[1]), .ser_clk(SER_CLK[1]),
        .rx_sample(RX_SAMPLE[1]), .rx_start(RX_START[1]), .done(done[1]), .count(cnt[1]));

    // --------------------------------------------------
    // Bus and compare tasks
    // --------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        BIT_MASK <= m;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask
    // Waits for a clean rising toggle so the first, shorter half is not measured
    task automatic measure(input int ch);
        int n;
        n = 0; hi = 0; lo = 0; ns = 0;
        #1;
        while (BAUD_OUT[ch] !== 1'b0 && n < 9000) begin @(posedge MCLK); #1; n++; end
        while (BAUD_OUT[ch] !== 1'b1 && n < 9000) begin @(posedge MCLK); #1; n++; end
        while (BAUD_OUT[ch] === 1'b1 && n < 9000) begin ns += SER_CLK[ch]; hi++; @(posedge MCLK); #1; n++; end
        while (BAUD_OUT[ch] === 1'b0 && n < 9000) begin ns += SER_CLK[ch]; lo++; @(posedge MCLK); #1; n++; end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // --------------------------------------------------
    // Clock and watchdog
    // --------------------------------------------------
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    initial begin
        #600000;
        err_count++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        close_out();
    end

    // --------------------------------------------------
    // Tests
    // --------------------------------------------------
    initial begin
        SYS_RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 32'h0; WDATA = 8'h00; BIT_MASK = 8'hff; kick = 2'b00;
        err_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge MCLK);
        SYS_RST <= 1'b0;
        for (int c = 0; c < 2; c++) begin
            rd(A_MODE[c], rv); chk("mode reset", ubr_pkg::MODE_RST, rv);
            rd(A_CMP[c], rv); chk("compare reset", ubr_pkg::CMP_RST, rv);
            rd(A_SRC[c], rv); chk("source reset", 8'h00, rv);
        end
        rd(32'hfffffa40, rv); chk("unmapped read", 8'h00, rv);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(A_CMP[rows[i].ch], rows[i].cmp, 8'hff);
            wr(A_MODE[rows[i].ch], 8'h7c | rows[i].sel, 8'hff);
            rd(A_MODE[rows[i].ch], rv); chk("mode unused bits", {6'h00, rows[i].sel}, rv);
            wr(A_SRC[rows[i].ch], 8'h01, 8'hff);
            wr(A_MODE[rows[i].ch], 8'h80, 8'h80);
            rd(A_MODE[rows[i].ch], rv); chk("mode bit write", {6'h20, rows[i].sel}, rv);
            measure(rows[i].ch);
            chk("high half", rows[i].half, hi);
            chk("low half", rows[i].half, lo);
            chk("serial clocks per period", 1, ns);
            wr(A_MODE[rows[i].ch], 8'h00, 8'h80);
            @(posedge MCLK);
            repeat (20) begin @(posedge MCLK); #1; chk("disabled baud", 0, BAUD_OUT[rows[i].ch]); end
            $display("row %0d done", i);
        end
        // Rewrite of compare while running restarts the count
        wr(A_CMP[0], 8'h04, 8'hff);
        wr(A_MODE[0], 8'h80, 8'hff);
        measure(0);
        chk("running half", 8, hi);
        // Write lands four edges into the high half, so the high half grows to 4 plus 2 times 4
        repeat (2) @(posedge MCLK);
        wr(A_CMP[0], 8'h04, 8'hff);
        t = 4;
        #1;
        while (BAUD_OUT[0] === 1'b1 && t < 100) begin @(posedge MCLK); #1; t++; end
        chk("half after compare write", 12, t);
        wr(A_MODE[0], 8'h00, 8'hff);
        $display("compare clear test done");
        // Receive sampling: ch1 at system clock, ch2 from the generator, ch1 restarted
        wr(A_SRC[0], 8'h00, 8'hff);
        wr(A_CMP[1], 8'h01, 8'hff);
        wr(A_MODE[1], 8'h80, 8'hff);
        @(posedge MCLK); kick <= 2'b11;
        @(posedge MCLK); kick <= 2'b00;
        repeat (4) @(posedge MCLK);
        kick <= 2'b01;
        @(posedge MCLK); kick <= 2'b00;
        repeat (300) @(posedge MCLK);
        #1;
        for (int c = 0; c < 2; c++) begin
            chk("sample seen", 1, done[c]);
            chk("clocks per sample", 16, cnt[c]);
        end
        $display("receive timing test done");
        close_out();
    end
endmodule
